// file: common/uvep_pkg.sv
// How it works
// - Programmer drives byte and stable address
// - Chip select pulsed low 50 or 10 ms
// - Pulse kept within 45-55 or 9-11 ms
// - One pulse per address, any order
// - Never steady low chip select to program
// - Verify samples data after verify delay
// - Chip select per device, OE on read strobe
package uvep_pkg;
    localparam int CLK_NS              = 40;
    localparam int ADDR_W              = 12;
    localparam int DATA_W              = 8;
    // Timing figures as printed
    localparam int SETUP_US            = 2;    // Address, data and OE setup
    localparam int HOLD_US             = 2;    // Data and OE hold
    localparam int VERIFY_DATA_DELAY_US = 1;
    localparam int PULSE_STD_MS        = 50;
    localparam int PULSE_FAST_MS       = 10;
    localparam int ADDRESS_ACCESS_TIME_NS = 450;  // Plain default, grade dependent
    // Derived cycle counts (least times round up)
    localparam int SETUP_CYC  = (SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC   = (HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int VERIFY_CYC = (VERIFY_DATA_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS + 1;
    localparam int ACCESS_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS + 1;
    localparam int PULSE_STD_CYC  = PULSE_STD_MS * 1000000 / CLK_NS;
    localparam int PULSE_FAST_CYC = PULSE_FAST_MS * 1000000 / CLK_NS;
    localparam int CNT_W = 24;
    localparam int SYNC_CYC = 3;    // Extra wait covering the pin synchroniser
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;  // Blank cell value, also reset value

    typedef enum logic [6:0] {
        UVEP_IDLE   = 7'h01,
        UVEP_READ   = 7'h02,
        UVEP_SETUP  = 7'h04,
        UVEP_PULSE  = 7'h08,
        UVEP_HOLD   = 7'h10,
        UVEP_VERIFY = 7'h20,
        UVEP_DONE   = 7'h40
    } uvep_state_type;
endpackage

// file: design/uvep_host.sv
`timescale 1ns/1ps
module uvep_host #(
    parameter int PULSE_STD  = uvep_pkg::PULSE_STD_CYC,
    parameter int PULSE_FAST = uvep_pkg::PULSE_FAST_CYC
) (
    input  wire logic                       clock_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       rd_req_i,
    input  wire logic                       pgm_req_i,
    input  wire logic                       fast_grade_i,
    input  wire logic [uvep_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [uvep_pkg::DATA_W-1:0] wdata_i,
    output logic                            busy_o,
    output logic                            done_o,
    output logic                            verify_ok_o,
    output logic [uvep_pkg::DATA_W-1:0]     rdata_o,
    output logic [uvep_pkg::ADDR_W-1:0]     mem_addr_o,
    output logic                            chip_sel_n_o,
    output logic                            out_en_n_o,
    output logic                            vpp_on_o,
    input  wire logic [uvep_pkg::DATA_W-1:0] mem_data_i,
    output logic [uvep_pkg::DATA_W-1:0]     mem_data_o,
    output logic                            mem_data_oe_o
);
    import uvep_pkg::*;

    uvep_state_type         state;
    uvep_state_type         next_state;
    logic [CNT_W-1:0]       cnt;
    logic [CNT_W-1:0]       limit;
    logic [DATA_W-1:0]      sync1, sync2, sync3, data_stable;
    logic                   is_pgm;
    logic [DATA_W-1:0]      wbyte;
    wire                    cnt_done;
    wire  [CNT_W-1:0]       pulse_len;
    wire                    sel_phase;      // Chip select low in these states
    wire                    read_phase;     // Output enable low in these states
    wire                    pgm_phase;      // VPP and data drive held here

    // Data pins come from outside; three stages, accept when last two agree
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1       <= ERASED_BYTE;
            sync2       <= ERASED_BYTE;
            sync3       <= ERASED_BYTE;
            data_stable <= ERASED_BYTE;
        end else begin
            sync1 <= mem_data_i;
            sync2 <= sync1;
            sync3 <= sync2;
            if (sync2 == sync3)
                data_stable <= sync3;
        end
    end

    assign pulse_len = fast_grade_i ? CNT_W'(PULSE_FAST) : CNT_W'(PULSE_STD);
    assign cnt_done  = (cnt >= limit);

    // Phase decode from the next state, so pins move with the state register
    assign sel_phase  = (next_state == UVEP_READ) || (next_state == UVEP_PULSE)
                        || (next_state == UVEP_VERIFY);
    assign read_phase = (next_state == UVEP_READ) || (next_state == UVEP_VERIFY);
    assign pgm_phase  = (next_state == UVEP_SETUP) || (next_state == UVEP_PULSE)
                        || (next_state == UVEP_HOLD);

    // Sequencer: read, or setup, bounded pulse, hold, verify
    always_comb begin
        next_state = state;
        case (state)
            UVEP_IDLE:   if (pgm_req_i) next_state = UVEP_SETUP;
                         else if (rd_req_i) next_state = UVEP_READ;
            UVEP_READ:   if (cnt_done) next_state = UVEP_DONE;
            UVEP_SETUP:  if (cnt_done) next_state = UVEP_PULSE;
            UVEP_PULSE:  if (cnt_done) next_state = UVEP_HOLD;
            UVEP_HOLD:   if (cnt_done) next_state = UVEP_VERIFY;
            UVEP_VERIFY: if (cnt_done) next_state = UVEP_DONE;
            UVEP_DONE:   next_state = UVEP_IDLE;
            default:     next_state = UVEP_IDLE;
        endcase
    end

    // Load a fresh wait for each new state
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= UVEP_IDLE;
            cnt   <= '0;
            limit <= '0;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                cnt <= CNT_W'(1);
                case (next_state)
                    UVEP_READ:   limit <= CNT_W'(ACCESS_CYC + SYNC_CYC);
                    UVEP_SETUP:  limit <= CNT_W'(SETUP_CYC);
                    UVEP_PULSE:  limit <= pulse_len;
                    UVEP_HOLD:   limit <= CNT_W'(HOLD_CYC);
                    UVEP_VERIFY: limit <= CNT_W'(VERIFY_CYC + SYNC_CYC);
                    default:     limit <= CNT_W'(1);
                endcase
            end else begin
                cnt <= cnt + CNT_W'(1);
            end
        end
    end

    // Latch request fields; they stay fixed over the whole cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            is_pgm     <= 1'b0;
            wbyte      <= ERASED_BYTE;
            mem_addr_o <= '0;
        end else if (state == UVEP_IDLE && (pgm_req_i || rd_req_i)) begin
            is_pgm     <= pgm_req_i;
            wbyte      <= wdata_i;
            mem_addr_o <= addr_i;
        end
    end

    // Pin drive: one pulse per address; VPP held across setup/pulse/hold.
    // Registered so that no decode glitch ever reaches the part.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chip_sel_n_o  <= 1'b1;
            out_en_n_o    <= 1'b1;
            vpp_on_o      <= 1'b0;
            mem_data_o    <= ERASED_BYTE;
            mem_data_oe_o <= 1'b0;
        end else begin
            chip_sel_n_o  <= !sel_phase;
            out_en_n_o    <= !read_phase;
            vpp_on_o      <= pgm_phase;
            mem_data_oe_o <= pgm_phase;
            mem_data_o    <= wbyte;
        end
    end

    // Capture result at end of read or verify.
    // Sample point includes the synchroniser delay, so the byte is settled.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o     <= ERASED_BYTE;
            verify_ok_o <= 1'b0;
            done_o      <= 1'b0;
        end else begin
            done_o <= (next_state == UVEP_DONE && state != UVEP_DONE);
            if ((state == UVEP_READ || state == UVEP_VERIFY) && cnt_done) begin
                rdata_o     <= data_stable;
                verify_ok_o <= is_pgm && (data_stable == wbyte);
            end
        end
    end

    // Requests seen while busy are dropped, not queued
    assign busy_o = (state != UVEP_IDLE);

    // Steps of a programming cycle, shared by the checks below
    sequence pulse_start_s;
        $fell(chip_sel_n_o) && vpp_on_o;
    endsequence

    sequence pulse_end_s;
        $rose(chip_sel_n_o) && vpp_on_o;
    endsequence

    sequence vpp_drop_s;
        $fell(vpp_on_o);
    endsequence

    sequence verify_end_s;
        done_o && is_pgm;
    endsequence

    // Program pulse is never a short glitch
    property pulse_width_p;
        @(posedge clock_i) disable iff (!rst_n_i)
        pulse_start_s |-> !chip_sel_n_o [*8];
    endproperty
    pulse_len_a: assert property (pulse_width_p)
        else $error("program pulse too short");

    // Address and data frozen while the pulse is low
    vpp_around_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        !chip_sel_n_o && vpp_on_o |-> mem_data_oe_o && $stable(mem_addr_o)
            && $stable(mem_data_o))
        else $error("address or data moved during pulse");

    // Output enable never meets our own drive or VPP
    verify_oe_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        !out_en_n_o |-> !vpp_on_o && !mem_data_oe_o)
        else $error("output enable low with drive or VPP");

    // Pulse always ends; chip select is never parked low
    pulse_end_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        state == UVEP_PULSE |-> cnt <= limit)
        else $error("program pulse overran its length");

    // VPP comes up only while the part is deselected
    rise_vpp_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        $rose(vpp_on_o) |-> chip_sel_n_o [*2])
        else $error("VPP raised with chip select low");

    // VPP and data drive were up for the setup time before the pulse
    setup_time_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        pulse_start_s |-> $past(vpp_on_o, SETUP_CYC) && $past(mem_data_oe_o, SETUP_CYC))
        else $error("program pulse began before setup time");

    // VPP and data drive outlast the end of the pulse
    hold_vpp_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        pulse_end_s |-> (vpp_on_o && mem_data_oe_o) [*8])
        else $error("VPP or data dropped at pulse end");

    // VPP removed only after the full hold time
    hold_time_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        vpp_drop_s |-> $past(chip_sel_n_o, HOLD_CYC))
        else $error("VPP removed before hold time");

    // Verify result only after the data valid delay has passed
    verify_wait_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        verify_end_s |-> !$past(chip_sel_n_o, VERIFY_CYC) && !$past(out_en_n_o, VERIFY_CYC))
        else $error("verify sampled before data valid delay");

    // Output enable low only on the selected part
    oe_select_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        !out_en_n_o |-> !chip_sel_n_o)
        else $error("output enable low while deselected");

    // One result strobe per request
    done_once_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        done_o |=> !done_o)
        else $error("done held for more than one cycle");
endmodule

// file: testbench/uvep_dev_model.sv
`timescale 1ns/1ps
module uvep_dev_model (
    input  wire logic                        chip_sel_n_i,
    input  wire logic                        out_en_n_i,
    input  wire logic                        vpp_on_i,
    input  wire logic [uvep_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [uvep_pkg::DATA_W-1:0] data_i,
    output logic      [uvep_pkg::DATA_W-1:0] data_o
);
    import uvep_pkg::*;
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] last = 8'hFF;
    // Erased part reads all ones
    initial for (int i = 0; i < (1<<ADDR_W); i++) mem[i] = 8'hFF;
    // Cells only clear; a low select with VPP never writes, the rise of select writes
    always @(posedge chip_sel_n_i) begin
        if (vpp_on_i) begin
            mem[addr_i] = mem[addr_i] & data_i;
        end
    end
    // No pull-up: a floating bus shows the inverse of the last value
    always @* begin
        if (!chip_sel_n_i && !out_en_n_i && !vpp_on_i) begin
            data_o = mem[addr_i];
            last = mem[addr_i];
        end else begin
            data_o = ~last;
        end
    end
endmodule

// file: testbench/uv_eprom_read_program_port_tb.sv
`timescale 1ns/1ps
module uv_eprom_read_program_port_tb;
    import uvep_pkg::*;
    localparam int PSTD  = 20;
    localparam int PFAST = 10;
    logic              clock_i = 0, rst_n_i = 0, rd_req_i = 0, pgm_req_i = 0, fast_grade_i = 0;
    logic [ADDR_W-1:0] addr_i  = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic              busy_o, done_o, verify_ok_o, chip_sel_n_o, out_en_n_o, vpp_on_o;
    logic              mem_data_oe_o;
    logic [DATA_W-1:0] rdata_o, mem_data_o, dev_data, mem_data_i;
    logic [ADDR_W-1:0] mem_addr_o;
    logic [19:0]       held;
    int                mismatches = 0, num_checks = 0, pw = 0, pw_last = 0;
    int                ref_mem [int];
    always #20 clock_i = ~clock_i;
    // Shared data pins: host drive wins while enabled
    assign mem_data_i = mem_data_oe_o ? mem_data_o : dev_data;
    uvep_host #(.PULSE_STD(PSTD), .PULSE_FAST(PFAST)) uvep_host_inst (.clock_i, .rst_n_i,
        .rd_req_i, .pgm_req_i, .fast_grade_i, .addr_i, .wdata_i, .busy_o, .done_o, .verify_ok_o,
        .rdata_o, .mem_addr_o, .chip_sel_n_o, .out_en_n_o, .vpp_on_o, .mem_data_i, .mem_data_o,
        .mem_data_oe_o);
    uvep_dev_model uvep_dev_model_inst (.chip_sel_n_i(chip_sel_n_o), .out_en_n_i(out_en_n_o),
        .vpp_on_i(vpp_on_o), .addr_i(mem_addr_o), .data_i(mem_data_i), .data_o(dev_data));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Pulse width in clocks, sampled mid-cycle once the pins have settled
    always @(negedge clock_i) begin
        if (!chip_sel_n_o && vpp_on_o) begin
            if (pw != 0) check("pulse_hold", {mem_addr_o, mem_data_o}, held);
            held <= {mem_addr_o, mem_data_o};
            pw <= pw + 1;
        end else if (pw != 0) begin
            pw_last <= pw;
            pw <= 0;
        end
    end
    // One request held until done, then compared with the reference
    task automatic op(bit pgm, bit fast, int a, int d);
        int n;
        int e;
        n = 0;
        @(posedge clock_i);
        #1;
        pgm_req_i = pgm;
        rd_req_i = !pgm || ($urandom_range(1) != 0); // Program must win over read
        fast_grade_i = fast;
        addr_i = a[ADDR_W-1:0];
        wdata_i = d[DATA_W-1:0];
        while (done_o !== 1'b1) begin
            @(posedge clock_i);
            #1;
            n++;
            if (n > 400) begin
                mismatches++;
                close_out();
            end
        end
        pgm_req_i = 0;
        rd_req_i = 0;
        check("busy", busy_o, 1'b1);
        e = ref_mem.exists(a) ? ref_mem[a] : 'hFF;
        if (pgm) begin
            e = e & d & 'hFF;
            ref_mem[a] = e;
            check("pulse_width", pw_last, fast ? PFAST : PSTD);
        end
        check("verify_ok", verify_ok_o, pgm && e == (d & 'hFF));
        check("rdata", rdata_o, e);
        @(posedge clock_i);
        #1;
        check("busy_idle", busy_o, 1'b0);
    endtask
    initial begin
        int a;
        int d;
        void'($urandom(32'h4635));
        repeat (3) @(posedge clock_i);
        #1 rst_n_i = 1;
        op(0, 0, 'h000, 0);
        op(0, 0, 'hFFF, 0);
        $display("test erased read done");
        for (int i = 0; i < 6; i++) begin
            a = $urandom_range(4095);
            d = $urandom_range(255);
            op(1, i % 2, a, d);
            op(0, 0, a, 0);
            op(1, !(i % 2), a, $urandom_range(255));
            op(0, 0, a, 0);
            $display("test program pass %0d done", i);
        end
        // Reset between requests: pins go idle, stored bytes survive
        @(posedge clock_i);
        #1 rst_n_i = 0;
        repeat (3) @(posedge clock_i);
        #1;
        check("rst_cs", chip_sel_n_o, 1'b1);
        check("rst_vpp", vpp_on_o, 1'b0);
        check("rst_drive", mem_data_oe_o, 1'b0);
        check("rst_done", done_o, 1'b0);
        rst_n_i = 1;
        op(0, 0, a, 0);
        $display("test mid-run reset done");
        close_out();
    end
endmodule
